// ===== logic/uie_baud_gen.sv
`timescale 1ns/1ps
`include "uie_defines.svh"
module uie_baud_gen
  import uie_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic [15:0] DIVISOR,
  output logic             BAUD_TICK,
  output logic             OVS_TICK
);
  typedef struct packed {
    logic [15:0] div_cnt;
    logic [15:0] ovs_cnt;
    logic        ovs;
    logic        baud;
  } uie_bg_type;

  uie_bg_type st_r;
  uie_bg_type st_nxt;

  // divisor 0 halts the clock, as a disabled generator
  always_comb begin
    st_nxt = st_r;
    st_nxt.ovs = 1'b0;
    st_nxt.baud = 1'b0;
    if (DIVISOR != `UIE_ZERO16) begin
      if (st_r.div_cnt >= DIVISOR - 16'h0001) begin
        st_nxt.div_cnt = `UIE_ZERO16;
        st_nxt.ovs = 1'b1;
        if (st_r.ovs_cnt >= `UIE_OVS - 16'h0001) begin
          st_nxt.ovs_cnt = `UIE_ZERO16;
          st_nxt.baud = 1'b1;
        end else begin
          st_nxt.ovs_cnt = st_r.ovs_cnt + 16'h0001;
        end
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 16'h0001;
      end
    end else begin
      st_nxt.div_cnt = `UIE_ZERO16;
      st_nxt.ovs_cnt = `UIE_ZERO16;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign BAUD_TICK = st_r.baud;
  assign OVS_TICK  = st_r.ovs;
endmodule : uie_baud_gen

// ===== logic/uie_defines.svh
`ifndef UIE_DEFINES_SVH
`define UIE_DEFINES_SVH
`define UIE_ADDR_W        32
`define UIE_OFS_DLL       32'h5000_1100
`define UIE_OFS_IER_DLH   32'h5000_1104
`define UIE_OFS_IDENT_FIFO 32'h5000_1108
`define UIE_OFS_LINE_CTRL 32'h5000_110C
`define UIE_OFS_ISTAT     32'h5000_1180
`define UIE_OFS_IMASK     32'h5000_1184
`define UIE_BIT_PROG_TX   7
`define UIE_BIT_MSI       3
`define UIE_BIT_LSI       2
`define UIE_BIT_TX_EMPTY  1
`define UIE_BIT_RDA       0
`define UIE_BIT_DIV_ACC   7
`define UIE_BIT_FIFOEN    0
`define UIE_IER_MASK      8'h8F
`define UIE_IID_NONE      4'h1
`define UIE_IID_TX_EMPTY  4'h2
`define UIE_IID_MODEM     4'h0
`define UIE_IID_RDA       4'h4
`define UIE_IID_RLS       4'h6
`define UIE_IID_BUSY      4'h7
`define UIE_IID_CTO       4'hC
`define UIE_FIFOSE_ON     2'h3
`define UIE_OVS           16'h0010
`define UIE_ZERO8         8'h00
`define UIE_ZERO16        16'h0000
`define UIE_NEV           6
`endif

// ===== logic/uie_irq_enable.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "uie_defines.svh"
module uie_irq_enable
  import uie_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire logic                 CE,
  input  wire uie_pkg::uie_addr_type ADDR,
  input  wire logic [15:0]          WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic [15:0]               RDATA,
  input  wire logic                 RLS_PEND,
  input  wire logic                 RDA_PEND,
  input  wire logic                 CTO_PEND,
  input  wire logic                 TX_HOLD_EMPTY_PEND,
  input  wire logic                 MODEM_PEND,
  input  wire logic                 BUSY_PEND,
  input  wire logic                 FIFO_EN,
  output logic                      DIVISOR_LATCH_ACCESS,
  output logic [15:0]               DIVISOR,
  output logic                      PROG_TX_EMPTY_IRQ_MODE_EN,
  output logic [3:0]                IRQ_IDENTITY,
  output logic                      PORT_IRQ,
  output logic                      BAUD_TICK,
  output logic                      OVS_TICK,
  output logic                      IRQ
);
  import uie_pkg::*;

  typedef struct packed {
    logic [7:0]  ier;
    logic [7:0]  dlh;
    logic [7:0]  dll;
    logic [7:0]  line_ctrl;
    logic [5:0]  istat;
    logic [5:0]  imask;
    logic [15:0] rdata;
    logic [5:0]  pend_d;
  } uie_regs_type;

  uie_regs_type st_r;
  uie_regs_type st_nxt;

  logic [3:0] iid;
  logic       any_pend;
  logic [5:0] pend_vec;
  logic [5:0] pend_rise;

  function automatic logic hit(input uie_addr_type a, input uie_addr_type ofs);
    hit = (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // source ranking
  wire logic div_acc   = st_r.line_ctrl[`UIE_BIT_DIV_ACC];
  wire logic en_rls    = st_r.ier[`UIE_BIT_LSI];
  wire logic en_rda    = st_r.ier[`UIE_BIT_RDA];
  wire logic en_txe    = st_r.ier[`UIE_BIT_TX_EMPTY];
  wire logic en_modem  = st_r.ier[`UIE_BIT_MSI];
  wire logic cto_live  = CTO_PEND & FIFO_EN;

  // busy detect is not maskable here; it ranks just below line status
  always_comb begin
    iid = `UIE_IID_NONE;
    if (en_rls && RLS_PEND) begin
      iid = `UIE_IID_RLS;
    end else if (BUSY_PEND) begin
      iid = `UIE_IID_BUSY;
    end else if (en_rda && RDA_PEND) begin
      iid = `UIE_IID_RDA;
    end else if (en_rda && cto_live) begin
      iid = `UIE_IID_CTO;
    end else if (en_txe && TX_HOLD_EMPTY_PEND) begin
      iid = `UIE_IID_TX_EMPTY;
    end else if (en_modem && MODEM_PEND) begin
      iid = `UIE_IID_MODEM;
    end
  end

  assign any_pend  = (iid != `UIE_IID_NONE);
  assign pend_vec  = {BUSY_PEND, en_modem & MODEM_PEND, en_txe & TX_HOLD_EMPTY_PEND,
                      en_rda & cto_live, en_rda & RDA_PEND, en_rls & RLS_PEND};
  assign pend_rise = pend_vec & ~st_r.pend_d;

  ////////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    st_nxt = st_r;
    st_nxt.pend_d = pend_vec;
    st_nxt.rdata = `UIE_ZERO16;
    if (WR) begin
      if (hit(ADDR, `UIE_OFS_IER_DLH)) begin
        if (div_acc) begin
          st_nxt.dlh = WDATA[7:0];
        end else begin
          st_nxt.ier = WDATA[7:0] & `UIE_IER_MASK;
        end
      end else if (hit(ADDR, `UIE_OFS_DLL) && div_acc) begin
        st_nxt.dll = WDATA[7:0];
      end else if (hit(ADDR, `UIE_OFS_LINE_CTRL)) begin
        st_nxt.line_ctrl = WDATA[7:0];
      end else if (hit(ADDR, `UIE_OFS_IMASK)) begin
        st_nxt.imask = WDATA[`UIE_NEV-1:0];
      end
    end
    // write-one-to-clear, a new event in the same cycle wins
    if (WR && hit(ADDR, `UIE_OFS_ISTAT)) begin
      st_nxt.istat = st_r.istat & ~WDATA[`UIE_NEV-1:0];
    end
    st_nxt.istat = st_nxt.istat | pend_rise;
    if (RD) begin
      if (hit(ADDR, `UIE_OFS_IER_DLH)) begin
        st_nxt.rdata = {`UIE_ZERO8, div_acc ? st_r.dlh : st_r.ier};
      end else if (hit(ADDR, `UIE_OFS_DLL)) begin
        st_nxt.rdata = {`UIE_ZERO8, div_acc ? st_r.dll : `UIE_ZERO8};
      end else if (hit(ADDR, `UIE_OFS_IDENT_FIFO)) begin
        st_nxt.rdata = {`UIE_ZERO8, FIFO_EN ? `UIE_FIFOSE_ON : 2'b00, 2'b00, iid};
      end else if (hit(ADDR, `UIE_OFS_LINE_CTRL)) begin
        st_nxt.rdata = {`UIE_ZERO8, st_r.line_ctrl};
      end else if (hit(ADDR, `UIE_OFS_ISTAT)) begin
        st_nxt.rdata = {10'h000, st_r.istat};
      end else if (hit(ADDR, `UIE_OFS_IMASK)) begin
        st_nxt.rdata = {10'h000, st_r.imask};
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign RDATA                     = st_r.rdata;
  assign DIVISOR_LATCH_ACCESS      = div_acc;
  assign DIVISOR                   = {st_r.dlh, st_r.dll};
  assign PROG_TX_EMPTY_IRQ_MODE_EN = st_r.ier[`UIE_BIT_PROG_TX];
  assign IRQ_IDENTITY              = iid;
  assign PORT_IRQ                  = any_pend;
  assign IRQ                       = |(st_r.istat & st_r.imask);

  uie_baud_gen u_baud (
    .CLK       (CLK),
    .NRST      (NRST),
    .CE        (CE),
    .DIVISOR   (DIVISOR),
    .BAUD_TICK (BAUD_TICK),
    .OVS_TICK  (OVS_TICK)
  );
endmodule : uie_irq_enable

// ===== logic/uie_pkg.sv
package uie_pkg;
  `include "uie_defines.svh"
  typedef logic [`UIE_ADDR_W-1:0] uie_addr_type;
  typedef logic [15:0]            uie_word_type;
endpackage : uie_pkg

// ===== logic/uie_unused_placeholder_none.sv
`timescale 1ns/1ps

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  import uie_pkg::*;
  logic         CLK = 0, NRST = 0, WR = 0, RD = 0, FIFO_EN = 1, CE = 1;
  logic         BAUD_TICK, OVS_TICK;
  uie_addr_type ADDR = '0;
  logic [15:0]  WDATA = '0, RDATA, DIVISOR;
  logic [5:0]   pend = '0;
  logic [3:0]   IRQ_IDENTITY;
  logic         DIVISOR_LATCH_ACCESS, PROG_TX_EMPTY_IRQ_MODE_EN, PORT_IRQ, IRQ;
  int           err_total = 0, check_count = 0;
  always #4 CLK = ~CLK;
  uie_irq_enable DUT(.CLK, .NRST, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .RLS_PEND(pend[0]), .RDA_PEND(pend[1]), .CTO_PEND(pend[2]),
    .TX_HOLD_EMPTY_PEND(pend[3]),
    .MODEM_PEND(pend[4]), .BUSY_PEND(pend[5]), .FIFO_EN, .DIVISOR_LATCH_ACCESS, .DIVISOR,
    .PROG_TX_EMPTY_IRQ_MODE_EN, .IRQ_IDENTITY, .PORT_IRQ, .BAUD_TICK, .OVS_TICK, .IRQ);
  task chk(input logic [15:0] s, input logic [15:0] e, input string n);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input uie_addr_type a, input logic [15:0] d);
    WR <= 1; ADDR <= a; WDATA <= d;
    @(posedge CLK); WR <= 0; @(posedge CLK);
  endtask : wr
  task rd(input uie_addr_type a, input logic [15:0] e);
    RD <= 1; ADDR <= a;
    @(posedge CLK); RD <= 0; #1;
    chk(RDATA, e, "read data");
    @(posedge CLK);
  endtask : rd
  // pending inputs settle across one edge so sticky status sees the rise
  task setp(input logic [5:0] v);
    pend <= v; @(posedge CLK); #1;
  endtask : setp
  ////////////////////////////////////////////////////////////////
  task t_divisor;
    chk(DIVISOR, 16'h0000, "divisor at reset");
    chk(IRQ_IDENTITY, 4'h1, "identity at reset");
    rd(32'h5000_1104, 16'h0000);
    wr(32'h5000_110C, 16'h0080); wr(32'h5000_1100, 16'h0034); wr(32'h5000_1104, 16'h00FF);
    chk(DIVISOR, 16'hFF34, "divisor");
    rd(32'h5000_1104, 16'h00FF);
    wr(32'h5000_110C, 16'h0000);
    rd(32'h5000_1104, 16'h0000);
    $display("test divisor done");
  endtask : t_divisor
  task t_enable;
    wr(32'h5000_1104, 16'h00FF);
    rd(32'h5000_1104, 16'h008F);
    chk(PROG_TX_EMPTY_IRQ_MODE_EN, 1'b1, "tx empty mode");
    chk(DIVISOR, 16'hFF34, "divisor kept");
    wr(32'h5000_1104, 16'h000F);
    $display("test enable done");
  endtask : t_enable
  // divisor 2: oversample tick every 2 clocks, bit tick every 32
  task t_baud;
    int n_ovs;
    int n_baud;
    n_ovs = 0;
    n_baud = 0;
    wr(32'h5000_110C, 16'h0080); wr(32'h5000_1100, 16'h0002); wr(32'h5000_1104, 16'h0000);
    wr(32'h5000_110C, 16'h0000);
    repeat (40) @(posedge CLK);
    for (int i = 0; i < 64; i++) begin
      @(posedge CLK); #1;
      n_ovs += OVS_TICK;
      n_baud += BAUD_TICK;
    end
    chk(n_ovs[15:0], 16'd32, "oversample ticks");
    chk(n_baud[15:0], 16'd2, "bit ticks");
    $display("test baud done");
  endtask : t_baud
  task t_priority;
    logic [5:0] pv [7] = '{6'h3F, 6'h2E, 6'h1E, 6'h1C, 6'h18, 6'h10, 6'h00};
    logic [3:0] ev [7] = '{4'h6, 4'h7, 4'h4, 4'hC, 4'h2, 4'h0, 4'h1};
    for (int i = 0; i < 7; i++) begin
      setp(pv[i]);
      chk(IRQ_IDENTITY, ev[i], "identity");
      chk(PORT_IRQ, ev[i] != 4'h1, "port irq");
    end
    FIFO_EN <= 0; setp(6'h04);
    chk(IRQ_IDENTITY, 4'h1, "timeout without fifo");
    FIFO_EN <= 1; wr(32'h5000_1104, 16'h000D); setp(6'h08);
    chk(PORT_IRQ, 1'b0, "tx empty disabled");
    $display("test priority done");
  endtask : t_priority
  task t_irq;
    setp(6'h00); wr(32'h5000_1180, 16'h003F); wr(32'h5000_1184, 16'h0001);
    chk(IRQ, 1'b0, "irq idle");
    setp(6'h01);
    chk(IRQ, 1'b1, "irq raised");
    setp(6'h02);
    rd(32'h5000_1180, 16'h0003);
    chk(IRQ, 1'b1, "irq sticky");
    wr(32'h5000_1180, 16'h0001); #1;
    chk(IRQ, 1'b0, "irq cleared, rda masked");
    rd(32'h5000_1200, 16'h0000);
    CE <= 0; wr(32'h5000_110C, 16'h0080); #1;
    chk(DIVISOR_LATCH_ACCESS, 1'b0, "frozen by clock enable");
    CE <= 1; @(posedge CLK);
    $display("test irq done");
  endtask : t_irq
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(posedge CLK);
    NRST <= 1; @(posedge CLK);
    t_divisor; t_enable; t_baud; t_priority; t_irq;
    report_and_stop;
  end
  initial begin
    #100000; err_total++;
    report_and_stop;
  end
endmodule : tb
bind uie_irq_enable uie_irq_enable_sva u_sva(.*);

// ===== verification/uie_irq_enable_sva.sv
`timescale 1ns/1ps
module uie_irq_enable_sva
  import uie_pkg::*;
(
  input wire logic                  CLK,
  input wire logic                  NRST,
  input wire logic                  CE,
  input wire uie_pkg::uie_addr_type ADDR,
  input wire logic [15:0]           WDATA,
  input wire logic                  WR,
  input wire logic                  RD,
  input wire logic [15:0]           RDATA,
  input wire logic                  RLS_PEND,
  input wire logic                  RDA_PEND,
  input wire logic                  CTO_PEND,
  input wire logic                  TX_HOLD_EMPTY_PEND,
  input wire logic                  MODEM_PEND,
  input wire logic                  FIFO_EN,
  input wire logic                  DIVISOR_LATCH_ACCESS,
  input wire logic [15:0]           DIVISOR,
  input wire logic                  PROG_TX_EMPTY_IRQ_MODE_EN,
  input wire logic [3:0]            IRQ_IDENTITY,
  input wire logic                  PORT_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////
  chk_lcr_access: assert property (
    CE && WR && ADDR == 32'h5000_110C |=> DIVISOR_LATCH_ACCESS == $past(WDATA[7]))
    else $error("access bit not taken from write");
  chk_dlh_write: assert property (
    CE && WR && ADDR == 32'h5000_1104 && DIVISOR_LATCH_ACCESS
    |=> DIVISOR[15:8] == $past(WDATA[7:0])) else $error("divisor high byte wrong");
  chk_ier_write: assert property (
    CE && WR && ADDR == 32'h5000_1104 && !DIVISOR_LATCH_ACCESS
    |=> PROG_TX_EMPTY_IRQ_MODE_EN == $past(WDATA[7]) && $stable(DIVISOR))
    else $error("enable write wrong or touched divisor");
  chk_read_idle: assert property (
    CE && !RD |=> RDATA == 16'h0000) else $error("read data outside read slot");
  chk_rls_code: assert property (
    IRQ_IDENTITY == 4'h6 |-> RLS_PEND) else $error("line status code without cause");
  chk_rda_code: assert property (
    IRQ_IDENTITY == 4'h4 |-> RDA_PEND && !RLS_PEND) else $error("receive code wrong");
  chk_cto_code: assert property (
    IRQ_IDENTITY == 4'hC |-> CTO_PEND && FIFO_EN && !RLS_PEND && !RDA_PEND)
    else $error("timeout code wrong");
  chk_txe_code: assert property (
    IRQ_IDENTITY == 4'h2 |-> TX_HOLD_EMPTY_PEND && !RLS_PEND)
    else $error("tx empty code wrong");
  chk_modem_code: assert property (
    IRQ_IDENTITY == 4'h0 |-> MODEM_PEND) else $error("modem code without cause");
  chk_port_irq: assert property (
    PORT_IRQ == (IRQ_IDENTITY != 4'h1)) else $error("port irq disagrees with identity");
endmodule : uie_irq_enable_sva
